//--- rtl/wdgen_div.sv
// Purpose: Divide the clock into a one-cycle bus tick by a chosen ratio.
// Assumes: Ratio is at least two.
// Notes: Ratio change takes effect at once; a count already at or past the new end wraps on the next edge.
`timescale 1ns/1ns
module wdgen_div (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Control
	input  wire logic [3:0] ratio,
	// Tick out
	output logic            tick
);
	logic [3:0] count;
	wire        wrap = (count >= ratio - 4'h1);

	// Counter wraps at ratio, emitting one tick per period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= 4'h0;
			tick  <= 1'b0;
		end else begin
			count <= wrap ? 4'h0 : count + 4'h1;
			tick  <= wrap;
		end
	end

	chk_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
		tick |=> !tick) else $error("tick lasted two cycles");
endmodule

//--- rtl/wdgen_pkg.sv
// Purpose: Constants and types for the watchdog enable gating block.
// Assumes: AXI4-Lite slave with 32-bit data, one register per word.
// Notes: Printed offsets 0x3 and 0x1F are not multiples of four, so each
//        offset is kept as an index and the byte address is four times it.
// Operation
// - After reset the watchdog stays disabled until software enables it.
// - The watchdog runs only when the mask permits and enable is set.
// - Option register bit 0 at zero is the mask that permits the watchdog.
// - With override bit 7 set, option bit 0 is cleared like RAM.
// - Writing 1 to control bit 2 with the mask met starts the watchdog.
// - The oscillator is divided by ten or two, per option, for the bus.
// - Register 3 bit 0 maps the wake select view, wrong until written.
package wdgen_pkg;
	localparam logic [15:0] IDX_WAKE_VIEW = 16'h0003;
	localparam logic [15:0] IDX_OVR_CTRL  = 16'h001C;
	localparam logic [15:0] IDX_WDG_CTRL  = 16'h001F;
	localparam logic [15:0] IDX_OPTION    = 16'h1F00;
	localparam logic [15:0] IDX_WAKE_SEL  = 16'h0004;
	localparam logic [15:0] IDX_WDG_STAT  = 16'h0005;
	localparam int BIT_VIEW     = 0;
	localparam int BIT_OVR      = 7;
	localparam int BIT_WDG_EN   = 2;
	localparam int BIT_MASK     = 0;
	localparam int BIT_DIVSEL   = 1;
	localparam logic [7:0] RST_OPTION = 8'h01;
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [3:0] DIV_TEN    = 4'hA;
	localparam logic [3:0] DIV_TWO    = 4'h2;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic       active;
		logic       mask_ok;
		logic [7:0] option;
	} wdgen_stat_t;
endpackage

//--- rtl/wdgen_top.sv
// Purpose: Watchdog enable gating, option override and bus clock divider.
// Assumes: Single clock aclk; AXI4-Lite slave; one write, one read at a time.
// Notes: Watchdog counting itself lives elsewhere; this block drives enable.
//        Option writes land only while the override bit is set.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
module wdgen_top (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Block outputs
	output logic             watchdog_timer_en,
	output logic             bus_clk_tick,
	output logic             wake_view_en
);
	// Write address and data capture
	logic [31:0] aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;
	// Registers
	logic [7:0]  wake_view;
	logic [7:0]  ovr_ctrl;
	logic [7:0]  wdg_ctrl;
	logic [7:0]  option;
	logic [7:0]  wake_sel;
	logic        wake_sel_valid;
	logic        div_tick;
	wdgen_pkg::wdgen_stat_t stat;

	// Write address and data may arrive in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire do_wr   = aw_held && w_held && !s_axi_bvalid;
	wire [15:0] wr_idx = aw_addr[17:2];
	wire [15:0] rd_idx = s_axi_araddr[17:2];
	wire wr_lane = w_strb[0];

	// Write decode
	wire hit_view  = wr_idx == wdgen_pkg::IDX_WAKE_VIEW;
	wire hit_ovr   = wr_idx == wdgen_pkg::IDX_OVR_CTRL;
	wire hit_ctrl  = wr_idx == wdgen_pkg::IDX_WDG_CTRL;
	wire hit_opt   = wr_idx == wdgen_pkg::IDX_OPTION;
	wire hit_sel   = wr_idx == wdgen_pkg::IDX_WAKE_SEL;
	wire hit_stat  = wr_idx == wdgen_pkg::IDX_WDG_STAT;
	wire wr_mapped = hit_view || hit_ovr || hit_ctrl || hit_opt
		|| hit_sel || hit_stat;
	wire ovr_on    = ovr_ctrl[wdgen_pkg::BIT_OVR];
	// Under override the option byte is stored like RAM, so both the
	// mask bit and the divide select can be changed
	wire opt_wr    = do_wr && hit_opt && wr_lane && ovr_on;
	wire [7:0] next_option = w_data[7:0];
	// Only the enable bit of control is writable; others are kept
	wire ctrl_wr   = do_wr && hit_ctrl && wr_lane;

	// Mask satisfied when option bit 0 is zero
	wire mask_ok = !option[wdgen_pkg::BIT_MASK];
	// Run only when mask permits and enable bit set
	wire next_wdg_en = mask_ok && wdg_ctrl[wdgen_pkg::BIT_WDG_EN];

	assign stat.active  = watchdog_timer_en;
	assign stat.mask_ok = mask_ok;
	assign stat.option  = option;

	// Read decode; wake select reads all ones until written
	wire [7:0] sel_rd = wake_sel_valid ? wake_sel : 8'hFF;
	wire rd_view = rd_idx == wdgen_pkg::IDX_WAKE_VIEW;
	wire rd_ovr  = rd_idx == wdgen_pkg::IDX_OVR_CTRL;
	wire rd_ctrl = rd_idx == wdgen_pkg::IDX_WDG_CTRL;
	wire rd_opt  = rd_idx == wdgen_pkg::IDX_OPTION;
	wire rd_sel  = (rd_idx == wdgen_pkg::IDX_WAKE_SEL)
		&& wake_view[wdgen_pkg::BIT_VIEW];
	wire rd_stat = rd_idx == wdgen_pkg::IDX_WDG_STAT;
	wire [7:0] rd_byte = rd_view ? wake_view :
		rd_ovr  ? ovr_ctrl :
		rd_ctrl ? wdg_ctrl :
		rd_opt  ? stat.option :
		rd_sel  ? sel_rd :
		rd_stat ? {6'h00, stat.mask_ok, stat.active} : 8'h00;
	wire rd_ok = rd_view || rd_ovr || rd_ctrl || rd_opt || rd_sel || rd_stat;

	// Divide ratio from option bit 1: set selects ten, clear two
	wire [3:0] div_ratio = option[wdgen_pkg::BIT_DIVSEL] ?
		wdgen_pkg::DIV_TEN : wdgen_pkg::DIV_TWO;

	wdgen_div u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ratio   (div_ratio),
		.tick    (div_tick)
	);

	// Write channel handshake; accept each channel once per transaction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 32'h0000_0000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= wdgen_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr       <= s_axi_awaddr;
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? wdgen_pkg::RESP_OKAY :
					wdgen_pkg::RESP_SLVERR;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Register file; control starts disabled on reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_view      <= wdgen_pkg::RST_ZERO;
			ovr_ctrl       <= wdgen_pkg::RST_ZERO;
			wdg_ctrl       <= wdgen_pkg::RST_ZERO;
			option         <= wdgen_pkg::RST_OPTION;
			wake_sel_valid <= 1'b0;
		end else begin
			if (do_wr && hit_view && wr_lane)
				wake_view <= w_data[7:0];
			if (do_wr && hit_ovr && wr_lane)
				ovr_ctrl <= w_data[7:0];
			if (ctrl_wr)
				wdg_ctrl[wdgen_pkg::BIT_WDG_EN] <=
					w_data[wdgen_pkg::BIT_WDG_EN];
			if (opt_wr)
				option <= next_option;
			// Only the valid flag is reset, like the emulator outputs
			if (do_wr && hit_sel && wr_lane && wake_view[wdgen_pkg::BIT_VIEW])
				wake_sel_valid <= 1'b1;
		end
	end

	// Wake select storage is left without reset on purpose: only the
	// valid flag clears, so a fresh view reads ones until written
	always_ff @(posedge aclk) begin
		if (do_wr && hit_sel && wr_lane && wake_view[wdgen_pkg::BIT_VIEW])
			wake_sel <= w_data[7:0];
	end

	// Read channel: answer one cycle after address taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= wdgen_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, rd_byte};
			s_axi_rresp   <= rd_ok ? wdgen_pkg::RESP_OKAY :
				wdgen_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Registered block outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_timer_en <= 1'b0;
			bus_clk_tick      <= 1'b0;
			wake_view_en      <= 1'b0;
		end else begin
			watchdog_timer_en <= next_wdg_en;
			bus_clk_tick      <= div_tick;
			wake_view_en      <= wake_view[wdgen_pkg::BIT_VIEW];
		end
	end

	// Checks on the watchdog enable path
	chk_reset_disabled: assert property (@(posedge aclk)
		$rose(aresetn) |-> !watchdog_timer_en)
		else $error("watchdog enabled right after reset");

	chk_option_reset: assert property (@(posedge aclk)
		$rose(aresetn) |-> option == wdgen_pkg::RST_OPTION)
		else $error("option not at reset value after reset");

	chk_enable_needs_mask: assert property (@(posedge aclk)
		disable iff (!aresetn)
		watchdog_timer_en |-> $past(mask_ok))
		else $error("watchdog on without mask");

	chk_mask_polarity: assert property (@(posedge aclk)
		disable iff (!aresetn)
		option[wdgen_pkg::BIT_MASK] |=> !watchdog_timer_en)
		else $error("watchdog on while option bit 0 set");

	chk_override_write: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(do_wr && hit_opt && wr_lane && ovr_on && !w_data[0])
		|=> !option[0])
		else $error("override write did not clear option bit");

	chk_enable_start: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(ctrl_wr && w_data[2] && mask_ok && !opt_wr)
		|=> ##1 watchdog_timer_en)
		else $error("watchdog did not start");

	chk_ctrl_blocks: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!wdg_ctrl[wdgen_pkg::BIT_WDG_EN] |=> !watchdog_timer_en)
		else $error("watchdog on without the enable bit");

	chk_ctrl_others: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(wdg_ctrl & 8'hFB) == 8'h00)
		else $error("control bits other than enable changed");

	chk_option_locked: assert property (@(posedge aclk)
		disable iff (!aresetn)
		!ovr_on |=> $stable(option))
		else $error("option changed without override");

	// Checks on view, divider and bus answers
	chk_view_output: assert property (@(posedge aclk)
		disable iff (!aresetn)
		wake_view_en == $past(wake_view[wdgen_pkg::BIT_VIEW]))
		else $error("view output did not follow register");

	chk_sel_hidden: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(do_wr && hit_sel && !wake_view[wdgen_pkg::BIT_VIEW])
		|=> $stable(wake_sel_valid))
		else $error("wake select written while out of view");

	// A ratio change right after a tick moves the next wrap, so the
	// second tick is only demanded when the ratio was still two
	chk_tick_ratio: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(div_tick && div_ratio == 4'h2 && $stable(div_ratio))
		|=> !div_tick ##1 (div_tick || $past(div_ratio) != 4'h2))
		else $error("divide by two ratio wrong");

	chk_tick_output: assert property (@(posedge aclk)
		disable iff (!aresetn)
		bus_clk_tick == $past(div_tick))
		else $error("bus tick output out of step");

	chk_write_answer: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(aw_take && w_take) |=> ##1 s_axi_bvalid)
		else $error("write response not on time");

	chk_read_answer: assert property (@(posedge aclk)
		disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read data not on time");

	// Scenario covers
	cov_override: cover property (@(posedge aclk) opt_wr);
	cov_start: cover property (@(posedge aclk) $rose(watchdog_timer_en));
	cov_wake: cover property (@(posedge aclk) wake_sel_valid);
	cov_div_ten: cover property (@(posedge aclk)
		div_tick && div_ratio == wdgen_pkg::DIV_TEN);
	cov_mask_stop: cover property (@(posedge aclk)
		disable iff (!aresetn) $fell(watchdog_timer_en));
endmodule

//--- verification/wdgen_top_tb.sv
// Purpose: Self-checking bench for the watchdog enable gating block.
// Assumes: AXI4-Lite master tasks, one transfer at a time, 250 MHz clock.
// Notes: Option writes under override act like RAM, so both ratios run.
`timescale 1ns/1ns
`define CHK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("Error at %0t: got %h expected %h", $time, got, exp); \
	end \
end
module wdgen_top_tb;
	logic        aclk          = 1'b0;
	logic        aresetn       = 1'b0;
	logic [31:0] s_axi_awaddr  = 32'h0;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata   = 32'h0;
	logic [3:0]  s_axi_wstrb   = 4'hF;
	logic        s_axi_wvalid  = 1'b0;
	logic        s_axi_bready  = 1'b0;
	logic [31:0] s_axi_araddr  = 32'h0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready  = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, watchdog_timer_en, bus_clk_tick, wake_view_en;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, data;
	int          mismatches      = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	int          n;

	// Clock of 4 ns period
	always #2 aclk = ~aclk;

	wdgen_top i_wdgen_top (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .watchdog_timer_en(watchdog_timer_en),
		.bus_clk_tick(bus_clk_tick), .wake_view_en(wake_view_en)
	);

	// Verdict and end of run
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Hang guard, far above the roughly 150 cycles the tests need
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results;
		end
	end

	// Write: AW and W offered together, each dropped once taken
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Read: address held until taken, rready held until rvalid
	task automatic axi_rd(input logic [31:0] a);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Read with an OKAY answer and an expected byte
	task automatic chk_rd(input logic [31:0] a, input logic [7:0] exp);
		axi_rd(a);
		`CHK(resp, wdgen_pkg::RESP_OKAY)
		`CHK(data, {24'h000000, exp})
	endtask

	// Cycles from one bus tick to the next, left in n
	task automatic tick_gap;
		n = 0;
		while (bus_clk_tick !== 1'b1 && n < 50) begin
			@(posedge aclk);
			n++;
		end
		@(posedge aclk);
		n = 1;
		while (bus_clk_tick !== 1'b1 && n < 50) begin
			@(posedge aclk);
			n++;
		end
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK(watchdog_timer_en, 1'b0)
		chk_rd(32'h0000007C, 8'h00);
		chk_rd(32'h00007C00, wdgen_pkg::RST_OPTION);
		// Tick spacing under the reset divide ratio
		tick_gap;
		`CHK(n, 2)
		$display("test reset and divider done");
		// Enable with mask still off must not start the watchdog
		axi_wr(32'h0000007C, 32'h00000004);
		repeat (4) @(posedge aclk);
		`CHK(watchdog_timer_en, 1'b0)
		chk_rd(32'h0000007C, 8'h04);
		axi_wr(32'h0000007C, 32'h00000000);
		axi_wr(32'h00007C00, 32'h00000000);
		`CHK(resp, wdgen_pkg::RESP_OKAY)
		chk_rd(32'h00007C00, 8'h01);
		$display("test gated enable done");
		// Override, clear the mask bit, then enable
		axi_wr(32'h00000070, 32'h00000080);
		chk_rd(32'h00000070, 8'h80);
		axi_wr(32'h00007C00, 32'h00000000);
		chk_rd(32'h00007C00, 8'h00);
		chk_rd(32'h00000014, 8'h02);
		`CHK(watchdog_timer_en, 1'b0)
		axi_wr(32'h0000007C, 32'h00000004);
		repeat (4) @(posedge aclk);
		`CHK(watchdog_timer_en, 1'b1)
		chk_rd(32'h00000014, 8'h03);
		// Option as RAM: mask off stops it, mask on again restarts it at divide by ten
		axi_wr(32'h00007C00, 32'h00000003);
		repeat (4) @(posedge aclk);
		`CHK(watchdog_timer_en, 1'b0)
		axi_wr(32'h00007C00, 32'h00000002);
		chk_rd(32'h00007C00, 8'h02);
		tick_gap;
		`CHK(n, 10)
		`CHK(watchdog_timer_en, 1'b1)
		$display("test override enable done");
		// Wake select view reads wrong until written
		axi_wr(32'h0000000C, 32'h00000001);
		repeat (2) @(posedge aclk);
		`CHK(wake_view_en, 1'b1)
		chk_rd(32'h00000010, 8'hFF);
		axi_wr(32'h00000010, 32'h0000005A);
		chk_rd(32'h00000010, 8'h5A);
		// Unmapped place is refused both ways
		axi_rd(32'h00000040);
		`CHK(resp, wdgen_pkg::RESP_SLVERR)
		`CHK(data, 32'h00000000)
		axi_wr(32'h00000040, 32'h00000011);
		`CHK(resp, wdgen_pkg::RESP_SLVERR)
		$display("test wake view and unmapped done");
		// Reset in mid-run clears enable and reloads the option reset value, not wake storage
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK(watchdog_timer_en, 1'b0)
		chk_rd(32'h00007C00, wdgen_pkg::RST_OPTION);
		axi_wr(32'h00000010, 32'h00000033);
		axi_wr(32'h0000000C, 32'h00000001);
		chk_rd(32'h00000010, 8'hFF);
		$display("test mid-run reset done");
		results;
	end
endmodule
